// ### rtl/lpg_status.sv
`timescale 1ns/1ps

module lpg_status (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           reset_n,
  // register access port
  input  wire logic [lpg_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic                           reg_wr_en,
  input  wire logic [lpg_pkg::DATA_W-1:0]     reg_wr_data,
  input  wire logic                           reg_rd_en,
  output logic      [lpg_pkg::DATA_W-1:0]     reg_rd_data,
  output logic                                reg_rd_valid,
  // regulator power-good levels, asynchronous
  input  wire logic                           reg5_power_good,
  input  wire logic                           reg6_power_good,
  input  wire logic                           reg7_power_good,
  input  wire logic                           reg8_power_good,
  input  wire logic                           reg9_power_good,
  input  wire logic                           reg10_power_good,
  // flag view
  output logic                                reg5_pg_edge_flag,
  output logic                                reg6_pg_edge_flag,
  output logic                                reg7_pg_edge_flag,
  output logic                                reg8_pg_edge_flag,
  output logic                                reg9_pg_edge_flag,
  output logic                                reg10_pg_edge_flag,
  // mask view and masked interrupt request
  output logic      [lpg_pkg::NUM_REG-1:0]    ldo_pgood_edge_mask,
  output logic                                pg_irq_request
);

  lpg_pkg::lpg_state_t            state;
  lpg_pkg::lpg_state_t            next_state;
  logic [lpg_pkg::NUM_REG-1:0]    pg_async;
  logic [lpg_pkg::NUM_REG-1:0]    pg_edge;
  logic                           hit_status;
  logic                           hit_mask;
  logic [lpg_pkg::NUM_REG-1:0]    clear_bits;
  logic [lpg_pkg::NUM_REG-1:0]    next_status;
  logic [lpg_pkg::NUM_REG-1:0]    next_mask;

  // gather inputs in bit order: regulator five is bit 0
  assign pg_async = {reg10_power_good,
                     reg9_power_good,
                     reg8_power_good,
                     reg7_power_good,
                     reg6_power_good,
                     reg5_power_good};

  // synchronise and detect changes
  lpg_pg_sync #(
    .WIDTH    (lpg_pkg::NUM_REG)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .pg_async (pg_async),
    .pg_level (),
    .pg_edge  (pg_edge)
  );

  // address decode
  assign hit_status = (reg_addr == lpg_pkg::ADDR_STATUS);
  assign hit_mask   = (reg_addr == lpg_pkg::ADDR_MASK);

  // write-1-to-clear bits, reserved bits of the write data ignored
  assign clear_bits = (reg_wr_en && hit_status) ? reg_wr_data[lpg_pkg::NUM_REG-1:0]
                                                : lpg_pkg::STATUS_RESET;

  // sticky flags: clear first, then new edges set, so a coincident edge wins
  assign next_status = (state.status & ~clear_bits) | pg_edge;

  // mask register write, plain read/write storage of the six mask bits
  assign next_mask = (reg_wr_en && hit_mask) ? reg_wr_data[lpg_pkg::NUM_REG-1:0]
                                             : state.mask;

  // next state of the register file and read path
  always_comb begin
    next_state          = state;
    next_state.status   = next_status;
    next_state.mask     = next_mask;
    next_state.rd_valid = reg_rd_en;
    next_state.rd_data  = lpg_pkg::READ_IDLE;
    if (reg_rd_en) begin
      if (hit_status) begin
        next_state.rd_data = {lpg_pkg::RSVD_READ, state.status};
      end else if (hit_mask) begin
        next_state.rd_data = {lpg_pkg::RSVD_READ, state.mask};
      end else begin
        next_state.rd_data = lpg_pkg::READ_IDLE;                  // unmapped reads zero
      end
    end
    // request raised only by unmasked pending flags
    next_state.irq = |(next_status & ~next_mask);
  end

  // state register, power-on reset clears flags and sets masks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.status   <= lpg_pkg::STATUS_RESET;
      state.mask     <= lpg_pkg::MASK_RESET;
      state.rd_data  <= lpg_pkg::READ_IDLE;
      state.rd_valid <= 1'b0;
      state.irq      <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state register
  assign reg_rd_data         = state.rd_data;
  assign reg_rd_valid        = state.rd_valid;
  assign reg5_pg_edge_flag   = state.status[0];
  assign reg6_pg_edge_flag   = state.status[1];
  assign reg7_pg_edge_flag   = state.status[2];
  assign reg8_pg_edge_flag   = state.status[3];
  assign reg9_pg_edge_flag   = state.status[4];
  assign reg10_pg_edge_flag  = state.status[5];
  assign ldo_pgood_edge_mask = state.mask;
  assign pg_irq_request      = state.irq;

endmodule

// ### rtl/lpg_pkg.sv
package lpg_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // regulator channels, regulator five in bit 0 through regulator ten in bit 5
  localparam int unsigned NUM_REG = 6;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h3f;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h40;

  // reset values
  localparam logic [NUM_REG-1:0] STATUS_RESET = 6'h00;
  localparam logic [NUM_REG-1:0] MASK_RESET   = 6'h3f;
  localparam logic [DATA_W-1:0]  READ_IDLE    = 8'h00;

  // reserved upper bits of both registers read as this
  localparam logic [DATA_W-NUM_REG-1:0] RSVD_READ = 2'h0;

  // synchroniser fill: cycles after reset release until a real previous sample exists
  localparam int unsigned PRIME_CYCLES = 3;
  localparam int unsigned PRIME_W      = 2;

  // whole state of the status block
  typedef struct packed {
    logic [NUM_REG-1:0] status;
    logic [NUM_REG-1:0] mask;
    logic [DATA_W-1:0]  rd_data;
    logic               rd_valid;
    logic               irq;
  } lpg_state_t;

endpackage

// ### rtl/lpg_pg_sync.sv
`timescale 1ns/1ps

// two-flop synchroniser plus change detector, one lane per regulator
module lpg_pg_sync #(
  parameter int unsigned WIDTH = lpg_pkg::NUM_REG
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // asynchronous power-good levels
  input  wire logic [WIDTH-1:0] pg_async,
  // synchronised level and one-cycle change pulse
  output logic      [WIDTH-1:0] pg_level,
  output logic      [WIDTH-1:0] pg_edge
);

  typedef struct packed {
    logic [WIDTH-1:0]            meta;
    logic [WIDTH-1:0]            sync;
    logic [WIDTH-1:0]            prev;
    logic [WIDTH-1:0]            edge_p;
    logic [lpg_pkg::PRIME_W-1:0] fill;
  } lpg_sync_state_t;

  lpg_sync_state_t state;
  lpg_sync_state_t next_state;

  // next state: meta feeds only sync; edges suppressed until prev holds a real sample
  always_comb begin
    next_state        = state;
    next_state.meta   = pg_async;
    next_state.sync   = state.meta;
    next_state.prev   = state.sync;
    if (state.fill != lpg_pkg::PRIME_W'(lpg_pkg::PRIME_CYCLES)) begin
      next_state.fill = state.fill + 2'h1;
    end
    // both rising and falling edges count, each lane on its own input only
    for (int i = 0; i < WIDTH; i++) begin
      next_state.edge_p[i] = (state.fill == lpg_pkg::PRIME_W'(lpg_pkg::PRIME_CYCLES)) &&
                             (state.sync[i] ^ state.prev[i]);
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pg_level = state.prev;
  assign pg_edge  = state.edge_p;

endmodule

// ### tb/lpg_status_asserts.sv
`timescale 1ns/1ps
module lpg_status_asserts (
  // clock, reset and register port
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       reg_rd_valid,
  // flags, mask and request
  input wire logic       reg5_pg_edge_flag,
  input wire logic       reg6_pg_edge_flag,
  input wire logic       reg7_pg_edge_flag,
  input wire logic       reg8_pg_edge_flag,
  input wire logic       reg9_pg_edge_flag,
  input wire logic       reg10_pg_edge_flag,
  input wire logic [5:0] ldo_pgood_edge_mask,
  input wire logic       pg_irq_request
);
  // flag vector, regulator five in bit 0, and status write strobe
  wire [5:0] f = {reg10_pg_edge_flag, reg9_pg_edge_flag, reg8_pg_edge_flag,
                  reg7_pg_edge_flag, reg6_pg_edge_flag, reg5_pg_edge_flag};
  wire       wst = reg_wr_en && reg_addr == 8'h3f;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // read request step
  sequence s_rd(a); reg_rd_en && reg_addr == a; endsequence
  chk_rd_status: assert property (s_rd(8'h3f) |=> reg_rd_valid && reg_rd_data == {2'h0, $past(f)})
    else $error("status read wrong");
  chk_rd_mask: assert property (s_rd(8'h40) |=> reg_rd_data == {2'h0, $past(ldo_pgood_edge_mask)})
    else $error("mask read wrong");
  chk_rsvd_zero: assert property (reg_rd_data[7:6] == 2'h0)
    else $error("reserved bits set");
  chk_flag_hold: assert property (!wst |=> (~f & $past(f)) == 6'h00)
    else $error("flag dropped");
  chk_clear_keep: assert property (wst |=> (~$past(reg_wr_data[5:0]) & $past(f) & ~f) == 6'h00)
    else $error("unwritten flag cleared");
  chk_irq_mask: assert property (pg_irq_request == |(f & ~ldo_pgood_edge_mask))
    else $error("request wrong");
  chk_reset_vals: assert property ($rose(reset_n) |-> f == 6'h00 && ldo_pgood_edge_mask == 6'h3f)
    else $error("reset values wrong");
  chk_rd_idle: assert property (!reg_rd_en |=> !reg_rd_valid && reg_rd_data == 8'h00)
    else $error("read answer without request");
endmodule

bind lpg_status lpg_status_asserts chk_u (.*);

// ### tb/lpg_status_tb.sv
`timescale 1ns/1ps
module lpg_status_tb;
  logic        sys_clk, reset_n, reg_wr_en, reg_rd_en;
  logic [7:0]  reg_addr, reg_wr_data;
  logic [5:0]  pg, fl;
  logic [31:0] rs;
  wire  [7:0]  rdat;
  wire  [5:0]  fv, mk;
  wire         rv, irq;
  int          n_mismatch, n_tests;
  lpg_status dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(rdat), .reg_rd_valid(rv),
    .reg5_power_good(pg[0]), .reg6_power_good(pg[1]), .reg7_power_good(pg[2]), .reg8_power_good(pg[3]),
    .reg9_power_good(pg[4]), .reg10_power_good(pg[5]), .reg5_pg_edge_flag(fv[0]), .reg6_pg_edge_flag(fv[1]),
    .reg7_pg_edge_flag(fv[2]), .reg8_pg_edge_flag(fv[3]), .reg9_pg_edge_flag(fv[4]),
    .reg10_pg_edge_flag(fv[5]), .ldo_pgood_edge_mask(mk), .pg_irq_request(irq));
  // random step and expected flags after a pin change
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [5:0] nf(input logic [5:0] f, o, n);
    return f | (o ^ n);
  endfunction
  // compare, bus cycles, reset and verdict
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input string nm);
    @(negedge sys_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    chk(nm, rv === 1'b1 ? rdat : 8'hxx, e);
  endtask
  task automatic rst();
    reset_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    fl = 6'h00;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
    {n_mismatch, n_tests} = '0;
    rs = 32'hd268e2c0;
    pg = 6'h2a;
    rst();
    rd(8'h3f, 8'h00, "status");
    rd(8'h40, 8'h3f, "mask");
    rd(8'h55, 8'h00, "unmapped");
    wr(8'h3f, 8'hc0);
    rd(8'h3f, 8'h00, "reserved");
    for (int i = 0; i < 40; i++) begin
      rs = xs(rs);
      fl = nf(fl, pg, rs[5:0]);
      pg = rs[5:0];
      repeat (8) @(negedge sys_clk);
      rd(8'h3f, {2'h0, fl}, "edge");
      wr(8'h40, rs[15:8]);
      rd(8'h40, {2'h0, rs[13:8]}, "mask rw");
      chk("mask out", {2'h0, mk}, {2'h0, rs[13:8]});
      wr(8'h3f, rs[23:16]);
      fl = fl & ~rs[21:16];
      chk("flags", {2'h0, fv}, {2'h0, fl});
      chk("irq", {7'h00, irq}, {7'h00, |(fl & ~rs[13:8])});
    end
    // corner: an edge and its write-1 clear meet at one clock edge, the edge wins
    pg = pg ^ 6'h01;
    repeat (2) @(negedge sys_clk);
    wr(8'h3f, 8'h3f);
    fl = nf(6'h00, 6'h00, 6'h01);
    chk("edge beats clear", {2'h0, fv}, {2'h0, fl});
    pg = ~pg;
    repeat (8) @(negedge sys_clk);
    rst();
    rd(8'h3f, 8'h00, "por");
    rd(8'h40, 8'h3f, "por mask");
    results();
  end
endmodule
